/* swim_top.sv */
// Interrupt masks, sleep timing config and serial register access for the switch front end.
//
// Contract
// [RL1] Frame: address 31-25, write bit 24, data 23-0.
// [RL2] Mask 0 blocks, 1 allows change interrupts.
// [RL3] Programmable mask at 0x0d, bits 7-0.
// [RL4] Ground mask at 0x0e, bits 13-0.
// [RL5] Masks reset all enabled, unused bits zero.
// [RL6] Host may rewrite masks any time.
// [RL7] Sleep config 0x0f: wake 7-4, poll 3-0.
// [RL8] Nonzero wake select: wake and interrupt on expiry.
// [RL9] Wake select zero disables the timer.
// [RL10] Wake select codes map to fixed intervals.
// [RL11] Poll select sets interval between polling events.
// [RL12] Poll event turns sources on per channel.
// [RL13] Poll select codes map to fixed periods.
// [RL14] No wake enables means polling stops.
// [RL15] Reply: fault bit 23, flag 22, data.
// [RL16] Unused bits ignore writes, read zero.
`timescale 1ns/10ps
module swim_top
  import swim_pkg::*;
#(
  parameter int N_PROG   = 8,           // Programmable inputs.
  parameter int N_GND    = 14,          // Ground sense inputs.
  parameter int TICK_LEN = TICK_CYCLES  // Cycles per 0.1 ms tick; shorten in simulation.
) (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              sclk,
  input  wire logic              csB,
  input  wire logic              mosi,
  output logic                   miso_ff,
  output logic                   misoOeB_ff,
  input  wire logic [N_PROG-1:0] programmable_input,
  input  wire logic [N_GND-1:0]  ground_sense_input,
  input  wire logic              faultIn,
  input  wire logic              sleep_mode,
  input  wire logic              wakeEnableAny,
  output logic                   irqB_ff,
  output logic                   wakeUp_ff,
  output logic                   gndPollOn_ff,
  output logic                   batPollOn_ff
);

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  logic [2:0]        sclkSync_ff;   // Serial clock synchroniser plus edge stage.
  logic [2:0]        csSync_ff;     // Chip select synchroniser plus edge stage.
  logic [1:0]        mosiSync_ff;   // Serial data synchroniser.
  logic [1:0]        faultSync_ff;  // Fault summary synchroniser.
  logic [N_PROG-1:0] progS1_ff;     // First stage of programmable inputs.
  logic [N_PROG-1:0] progS2_ff;     // Synchronised programmable inputs.
  logic [N_PROG-1:0] progOld_ff;    // Previous programmable state.
  logic [N_GND-1:0]  gndS1_ff;      // First stage of ground inputs.
  logic [N_GND-1:0]  gndS2_ff;      // Synchronised ground inputs.
  logic [N_GND-1:0]  gndOld_ff;     // Previous ground state.
  logic [23:0]       progMask_ff;   // Programmable input interrupt mask.
  logic [23:0]       gndMask_ff;    // Ground input interrupt mask.
  logic [23:0]       sleepCfg_ff;   // Sleep timing configuration.
  logic [31:0]       rxShift_ff;    // Incoming frame.
  logic [31:0]       txShift_ff;    // Outgoing reply.
  logic [5:0]        bitCnt_ff;     // Bits taken in the current frame.
  logic [6:0]        lastAddr_ff;   // Address whose content the next reply carries.
  logic              irqFlag_ff;    // Sticky pending interrupt flag.
  logic              sclkRise;      // Synchronised serial clock rising edge.
  logic              sclkFall;      // Synchronised serial clock falling edge.
  logic              csFall;        // Frame start.
  logic              csRise;        // Frame end.
  logic              frameDone;     // A complete frame ended.
  logic              isWrite;       // Completed frame is a write.
  logic [6:0]        rxAddr;        // Address of the completed frame.
  logic [23:0]       rxData;        // Payload of the completed frame.
  logic [23:0]       rdData;        // Content of the last addressed register.
  logic [31:0]       reply;         // Reply word loaded at frame start.
  logic              changeIrq;     // Enabled input changed in normal mode.

  swim_tmr_if tif ();

  // ---------------------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------------------
  // Every pin passes two flops; the third serial stage only feeds edge detection.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sclkSync_ff  <= 3'h0;
      csSync_ff    <= 3'h7;
      mosiSync_ff  <= 2'h0;
      faultSync_ff <= 2'h0;
    end else begin
      sclkSync_ff  <= {sclkSync_ff[1:0], sclk};
      csSync_ff    <= {csSync_ff[1:0], csB};
      mosiSync_ff  <= {mosiSync_ff[0], mosi};
      faultSync_ff <= {faultSync_ff[0], faultIn};
    end
  end

  // Switch inputs get two stages plus a held copy for change detection.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      progS1_ff  <= '0;
      progS2_ff  <= '0;
      progOld_ff <= '0;
      gndS1_ff   <= '0;
      gndS2_ff   <= '0;
      gndOld_ff  <= '0;
    end else begin
      progS1_ff  <= programmable_input;
      progS2_ff  <= progS1_ff;
      progOld_ff <= progS2_ff;
      gndS1_ff   <= ground_sense_input;
      gndS2_ff   <= gndS1_ff;
      gndOld_ff  <= gndS2_ff;
    end
  end

  assign sclkRise = sclkSync_ff[1] && !sclkSync_ff[2];
  assign sclkFall = !sclkSync_ff[1] && sclkSync_ff[2];
  assign csFall   = !csSync_ff[1] && csSync_ff[2];
  assign csRise   = csSync_ff[1] && !csSync_ff[2];

  // ---------------------------------------------------------------------------
  // Frame decode
  // ---------------------------------------------------------------------------
  assign frameDone = csRise && (bitCnt_ff == BIT_CNT_FULL);
  assign rxAddr    = rxShift_ff[ADDR_MSB:ADDR_LSB];   // [RL1]
  assign isWrite   = rxShift_ff[RW_BIT];              // [RL1]
  assign rxData    = rxShift_ff[DATA_BITS-1:0];       // [RL1]

  // Reads of unmapped addresses return zero data.
  always_comb begin
    unique case (lastAddr_ff)
      ADDR_PROG_MASK: rdData = progMask_ff;
      ADDR_GND_MASK:  rdData = gndMask_ff;
      ADDR_SLEEP_CFG: rdData = sleepCfg_ff;
      default:        rdData = 24'h000000;
    endcase
  end

  // Reply carries fault, pending flag, then the register content.
  assign reply = {8'h00, faultSync_ff[1], irqFlag_ff, rdData[RESP_DATA-1:0]};  // [RL15]

  // ---------------------------------------------------------------------------
  // Serial shift registers
  // ---------------------------------------------------------------------------
  // Bits are taken on rising serial clock, MSB first; frames shorter than
  // 32 bits are dropped at chip select release, longer ones keep the last 32.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rxShift_ff <= 32'h00000000;
      bitCnt_ff  <= 6'h00;
    end else if (csFall) begin
      bitCnt_ff  <= 6'h00;
    end else if (!csSync_ff[1] && sclkRise) begin
      rxShift_ff <= {rxShift_ff[FRAME_BITS-2:0], mosiSync_ff[1]};
      bitCnt_ff  <= (bitCnt_ff == BIT_CNT_FULL) ? bitCnt_ff : bitCnt_ff + 6'h01;
    end
  end

  // Reply is launched at frame start and advanced on falling serial clock.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      txShift_ff <= 32'h00000000;
      miso_ff    <= 1'b0;
      misoOeB_ff <= 1'b1;
    end else if (csFall) begin
      txShift_ff <= {reply[FRAME_BITS-2:0], 1'b0};
      miso_ff    <= reply[FRAME_BITS-1];
      misoOeB_ff <= 1'b0;
    end else if (csRise) begin
      misoOeB_ff <= 1'b1;
    end else if (!csSync_ff[1] && sclkFall) begin
      txShift_ff <= {txShift_ff[FRAME_BITS-2:0], 1'b0};
      miso_ff    <= txShift_ff[FRAME_BITS-1];
    end
  end

  // The address of every complete frame selects the next reply's content.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      lastAddr_ff <= 7'h00;
    end else if (frameDone) begin
      lastAddr_ff <= rxAddr;
    end
  end

  // ---------------------------------------------------------------------------
  // Register bank
  // ---------------------------------------------------------------------------
  // Writes land whenever a frame completes; unused bits are masked off.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      progMask_ff <= PROG_MASK_RST;   // [RL5]
      gndMask_ff  <= GND_MASK_RST;    // [RL5]
      sleepCfg_ff <= SLEEP_CFG_RST;   // [RL7]
    end else if (frameDone && isWrite) begin  // [RL6]
      if (rxAddr == ADDR_PROG_MASK) begin
        progMask_ff <= rxData & PROG_MASK_BITS;  // [RL3] [RL16]
      end
      if (rxAddr == ADDR_GND_MASK) begin
        gndMask_ff <= rxData & GND_MASK_BITS;    // [RL4] [RL16]
      end
      if (rxAddr == ADDR_SLEEP_CFG) begin
        sleepCfg_ff <= rxData & SLEEP_CFG_BITS;  // [RL7] [RL16]
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Interrupt flag
  // ---------------------------------------------------------------------------
  // Only enabled inputs that change while awake, and the wake tick, raise the flag.
  assign changeIrq = !sleep_mode &&
                     ((|((progS2_ff ^ progOld_ff) & progMask_ff[N_PROG-1:0])) ||   // [RL2]
                      (|((gndS2_ff ^ gndOld_ff) & gndMask_ff[N_GND-1:0])));     // [RL2]

  // A complete frame clears the flag, but a new event in that cycle wins.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      irqFlag_ff <= 1'b0;
    end else if (changeIrq || tif.wakeTick) begin
      irqFlag_ff <= 1'b1;  // [RL8]
    end else if (frameDone) begin
      irqFlag_ff <= 1'b0;
    end
  end

  // Pin outputs: active low interrupt, wake pulse, polling windows.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      irqB_ff      <= 1'b1;
      wakeUp_ff    <= 1'b0;
      gndPollOn_ff <= 1'b0;
      batPollOn_ff <= 1'b0;
    end else begin
      irqB_ff      <= !(irqFlag_ff || changeIrq || tif.wakeTick);
      wakeUp_ff    <= tif.wakeTick;  // [RL8]
      gndPollOn_ff <= tif.gndPollOn;  // [RL12]
      batPollOn_ff <= tif.batPollOn;  // [RL12]
    end
  end

  // ---------------------------------------------------------------------------
  // Sleep timer
  // ---------------------------------------------------------------------------
  assign tif.sleepMode  = sleep_mode;
  assign tif.wakeSel    = sleepCfg_ff[WAKE_SEL_LSB+3:WAKE_SEL_LSB];
  assign tif.pollSel    = sleepCfg_ff[POLL_SEL_LSB+3:POLL_SEL_LSB];
  assign tif.pollEnable = wakeEnableAny;  // [RL14]

  swim_sleep_timer #(
    .TICK_LEN (TICK_LEN)
  ) u_timer (
    .clk   (clk),
    .rst_b (rst_b),
    .tif   (tif)
  );

endmodule : swim_top

/* swim_pkg.sv */
// Constants, code tables and helpers shared by the switch interrupt mask block.
package swim_pkg;

  // ---------------------------------------------------------------------------
  // Frame layout
  // ---------------------------------------------------------------------------
  localparam int          FRAME_BITS   = 32;      // Bits in one serial frame.
  localparam int          ADDR_MSB     = 31;      // Top bit of the register address.
  localparam int          ADDR_LSB     = 25;      // Bottom bit of the register address.
  localparam int          RW_BIT       = 24;      // Read/write select, 1 means write.
  localparam int          DATA_BITS    = 24;      // Payload width.
  localparam int          RESP_FAULT   = 23;      // Fault summary position in a reply.
  localparam int          RESP_IRQ     = 22;      // Pending flag position in a reply.
  localparam int          RESP_DATA    = 22;      // Register data bits in a reply.
  localparam logic [5:0]  BIT_CNT_FULL = 6'h20;   // Count of a complete frame.

  // ---------------------------------------------------------------------------
  // Register offsets, reset values and writable masks
  // ---------------------------------------------------------------------------
  localparam logic [6:0]  ADDR_PROG_MASK  = 7'h0d;       // Programmable input mask.
  localparam logic [6:0]  ADDR_GND_MASK   = 7'h0e;       // Ground input mask.
  localparam logic [6:0]  ADDR_SLEEP_CFG  = 7'h0f;       // Sleep timing config.
  localparam logic [23:0] PROG_MASK_RST   = 24'h0000ff;  // All eight enabled.
  localparam logic [23:0] GND_MASK_RST    = 24'h003fff;  // All fourteen enabled.
  localparam logic [23:0] SLEEP_CFG_RST   = 24'h00000f;  // Timer off, poll code 1111.
  localparam logic [23:0] PROG_MASK_BITS  = 24'h0000ff;  // Implemented mask bits.
  localparam logic [23:0] GND_MASK_BITS   = 24'h003fff;  // Implemented mask bits.
  localparam logic [23:0] SLEEP_CFG_BITS  = 24'h0000ff;  // Implemented config bits.
  localparam int          WAKE_SEL_LSB    = 4;           // Wake timer select field.
  localparam int          POLL_SEL_LSB    = 0;           // Polling period select field.
  localparam logic [3:0]  TIMER_OFF       = 4'h0;        // Wake timer disabled.

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 40;                          // System clock period.
  localparam int TICK_NS         = 100000;                      // Timer tick of 0.1 ms.
  localparam int TICK_CYCLES     = TICK_NS / CLK_PERIOD_NS;     // Cycles per tick.
  localparam int GND_POLL_ON_NS  = 64000;                       // Ground poll on time.
  localparam int BAT_POLL_ON_NS  = 64000;                       // Battery poll on time.
  localparam int GND_POLL_CYCLES = (GND_POLL_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BAT_POLL_CYCLES = (BAT_POLL_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Wake interval in 0.1 ms ticks for each select code.
  function automatic logic [15:0] swim_wake_ticks(input logic [3:0] code);
    logic [15:0] t;
    t = 16'h0000;
    unique case (code)
      4'h0: t = 16'h0000;  // Off.
      4'h1: t = 16'd60;    // 6.0 ms.
      4'h2: t = 16'd120;   // 12 ms.
      4'h3: t = 16'd240;   // 24 ms.
      4'h4: t = 16'd480;   // 48 ms.
      4'h5: t = 16'd480;   // 48 ms, same as code 0100.
      4'h6: t = 16'd960;   // 96 ms.
      4'h7: t = 16'd3940;  // 394 ms.
      4'h8: t = 16'd40;    // 4.0 ms.
      4'h9: t = 16'd80;    // 8.0 ms.
      4'ha: t = 16'd160;   // 16 ms.
      4'hb: t = 16'd320;   // 32 ms.
      4'hc: t = 16'd640;   // 64 ms.
      4'hd: t = 16'd1280;  // 128 ms.
      4'he: t = 16'd2560;  // 256 ms.
      4'hf: t = 16'd5120;  // 512 ms.
    endcase
    return t;
  endfunction : swim_wake_ticks

  // Polling period in 0.1 ms ticks for each select code.
  function automatic logic [15:0] swim_poll_ticks(input logic [3:0] code);
    logic [15:0] t;
    t = 16'h0000;
    unique case (code)
      4'h0: t = 16'd30;    // 3.0 ms.
      4'h1: t = 16'd60;    // 6.0 ms.
      4'h2: t = 16'd120;   // 12 ms.
      4'h3: t = 16'd240;   // 24 ms.
      4'h4: t = 16'd480;   // 48 ms.
      4'h5: t = 16'd680;   // 68 ms.
      4'h6: t = 16'd760;   // 76 ms.
      4'h7: t = 16'd1280;  // 128 ms.
      4'h8: t = 16'd320;   // 32 ms.
      4'h9: t = 16'd360;   // 36 ms.
      4'ha: t = 16'd400;   // 40 ms.
      4'hb: t = 16'd440;   // 44 ms.
      4'hc: t = 16'd520;   // 52 ms.
      4'hd: t = 16'd560;   // 56 ms.
      4'he: t = 16'd660;   // 66 ms.
      4'hf: t = 16'd640;   // 64 ms.
    endcase
    return t;
  endfunction : swim_poll_ticks

endpackage : swim_pkg

/* swim_tmr_if.sv */
// Signals between the register core and the sleep timer module.
`timescale 1ns/10ps
interface swim_tmr_if;
  logic       sleepMode;     // Device is in sleep mode.
  logic [3:0] wakeSel;       // Wake timer select code.
  logic [3:0] pollSel;       // Polling period select code.
  logic       pollEnable;    // Some channel may wake the device.
  logic       wakeTick;      // One-cycle pulse when the wake interval ends.
  logic       gndPollOn;     // Ground channel current sources on.
  logic       batPollOn;     // Battery channel current sources on.

  modport core (output sleepMode, wakeSel, pollSel, pollEnable,
                input  wakeTick, gndPollOn, batPollOn);
  modport tmr  (input  sleepMode, wakeSel, pollSel, pollEnable,
                output wakeTick, gndPollOn, batPollOn);
endinterface : swim_tmr_if

/* swim_sleep_timer.sv */
// Wake interval timer and polling event sequencer used during sleep mode.
`timescale 1ns/10ps
module swim_sleep_timer
  import swim_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst_b,
  swim_tmr_if.tmr  tif
);

  // ---------------------------------------------------------------------------
  // Tick prescaler
  // ---------------------------------------------------------------------------
  logic [15:0] preCnt_ff;   // Cycles within the current tick.
  logic        tick_ff;     // One-cycle pulse per tick.
  logic [15:0] wakeCnt_ff;  // Ticks elapsed in the wake interval.
  logic [15:0] pollCnt_ff;  // Ticks elapsed in the polling period.
  logic [11:0] gndCnt_ff;   // Ground on-time remaining.
  logic [11:0] batCnt_ff;   // Battery on-time remaining.
  logic        wakeTick_ff; // Wake pulse register.
  logic        pollEvt;     // Polling period has ended.

  // The prescaler runs only in sleep mode so every interval starts fresh.
  always_ff @(posedge clk) begin
    if (!rst_b || !tif.sleepMode) begin
      preCnt_ff <= 16'h0000;
      tick_ff   <= 1'b0;
    end else if (preCnt_ff == 16'(TICK_LEN - 1)) begin
      preCnt_ff <= 16'h0000;
      tick_ff   <= 1'b1;
    end else begin
      preCnt_ff <= preCnt_ff + 16'h0001;
      tick_ff   <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Wake interval timer
  // ---------------------------------------------------------------------------
  // A zero select keeps the counter parked, so no timed wake ever fires.
  always_ff @(posedge clk) begin
    if (!rst_b || !tif.sleepMode || tif.wakeSel == TIMER_OFF) begin  // [RL9]
      wakeCnt_ff  <= 16'h0000;
      wakeTick_ff <= 1'b0;
    end else if (tick_ff && wakeCnt_ff + 16'h0001 >= swim_wake_ticks(tif.wakeSel)) begin
      wakeCnt_ff  <= 16'h0000;
      wakeTick_ff <= 1'b1;  // [RL8] [RL10]
    end else begin
      wakeCnt_ff  <= tick_ff ? wakeCnt_ff + 16'h0001 : wakeCnt_ff;
      wakeTick_ff <= 1'b0;
    end
  end

  assign tif.wakeTick = wakeTick_ff;

  // ---------------------------------------------------------------------------
  // Polling period and current source windows
  // ---------------------------------------------------------------------------
  assign pollEvt = tick_ff && (pollCnt_ff + 16'h0001 >= swim_poll_ticks(tif.pollSel));

  // Polling stops when no channel is allowed to wake the device.
  always_ff @(posedge clk) begin
    if (!rst_b || !tif.sleepMode || !tif.pollEnable) begin  // [RL14]
      pollCnt_ff <= 16'h0000;
    end else if (pollEvt) begin
      pollCnt_ff <= 16'h0000;  // [RL11] [RL13]
    end else if (tick_ff) begin
      pollCnt_ff <= pollCnt_ff + 16'h0001;
    end
  end

  // Each polling event opens both source windows for their own on times.
  always_ff @(posedge clk) begin
    if (!rst_b || !tif.sleepMode || !tif.pollEnable) begin
      gndCnt_ff <= 12'h000;
      batCnt_ff <= 12'h000;
    end else if (pollEvt) begin
      gndCnt_ff <= 12'(GND_POLL_CYCLES);  // [RL12]
      batCnt_ff <= 12'(BAT_POLL_CYCLES);  // [RL12]
    end else begin
      gndCnt_ff <= (gndCnt_ff != 12'h000) ? gndCnt_ff - 12'h001 : gndCnt_ff;
      batCnt_ff <= (batCnt_ff != 12'h000) ? batCnt_ff - 12'h001 : batCnt_ff;
    end
  end

  // Window outputs follow the remaining counts one cycle later.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tif.gndPollOn <= 1'b0;
      tif.batPollOn <= 1'b0;
    end else begin
      tif.gndPollOn <= (gndCnt_ff != 12'h000);
      tif.batPollOn <= (batCnt_ff != 12'h000);
    end
  end

endmodule : swim_sleep_timer

/* swim_top_asserts.sv */
// Port-level checks for the switch interrupt mask block.
`timescale 1ns/10ps
module swim_top_asserts (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic csB,
  input wire logic misoOeB_ff,
  input wire logic irqB_ff,
  input wire logic wakeUp_ff,
  input wire logic sleep_mode,
  input wire logic gndPollOn_ff,
  input wire logic batPollOn_ff
);
  // All checks share the system clock and, except a_rst, are idle while reset is low.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_rst; disable iff (1'b0) !rst_b |=> misoOeB_ff && irqB_ff && !wakeUp_ff; endproperty
  a_rst: assert property (p_rst) else $error("outputs not idle after reset");
  property p_oe_on; $fell(csB) |-> ##[2:5] !misoOeB_ff; endproperty
  a_oe_on: assert property (p_oe_on) else $error("reply not driven");
  property p_oe_off; csB [*6] |-> misoOeB_ff; endproperty
  a_oe_off: assert property (p_oe_off) else $error("reply driven while idle");
  property p_wk_pulse; wakeUp_ff |=> !wakeUp_ff; endproperty
  a_wk_pulse: assert property (p_wk_pulse) else $error("wake pulse too long");
  property p_wk_mode; wakeUp_ff |-> $past(sleep_mode, 3); endproperty
  a_wk_mode: assert property (p_wk_mode) else $error("wake outside sleep");
  property p_wk_irq; wakeUp_ff |-> ##[1:3] !irqB_ff; endproperty
  a_wk_irq: assert property (p_wk_irq) else $error("wake without interrupt");
  property p_poll_off; !sleep_mode [*4] |-> !gndPollOn_ff && !batPollOn_ff; endproperty
  a_poll_off: assert property (p_poll_off) else $error("poll while awake");
  property p_poll_pair; $rose(gndPollOn_ff) |-> batPollOn_ff; endproperty
  a_poll_pair: assert property (p_poll_pair) else $error("poll windows apart");
  property p_poll_len; $rose(gndPollOn_ff) |=> gndPollOn_ff [*8]; endproperty
  a_poll_len: assert property (p_poll_len) else $error("poll window short");
  c_wake: cover property (wakeUp_ff);
  c_irq: cover property ($fell(irqB_ff));
  c_poll: cover property ($rose(gndPollOn_ff));
endmodule : swim_top_asserts
bind swim_top swim_top_asserts u_chk (.clk, .rst_b, .csB, .misoOeB_ff, .irqB_ff, .wakeUp_ff,
  .sleep_mode, .gndPollOn_ff, .batPollOn_ff);

/* swim_host_model.sv */
// Host serial master model: frames commands MSB first and collects replies.
`timescale 1ns/10ps
module swim_host_model (
  input  wire logic clk,
  input  wire logic miso_ff,
  input  wire logic misoOeB_ff,
  output logic      sclk,
  output logic      csB,
  output logic      mosi
);
  // The serial clock stands low and the select high between frames.
  initial begin
    sclk = 1'b0;
    csB  = 1'b1;
    mosi = 1'b0;
  end
  // Sends the top n bits of cmd; a released reply line reads as unknown.
  task automatic xfer(input logic [31:0] cmd, input int n, output logic [31:0] rep);
    rep = '0;
    @(negedge clk);
    csB = 1'b0;
    repeat (4) @(negedge clk);
    for (int i = 31; i > 31 - n; i--) begin
      mosi = cmd[i];
      repeat (4) @(negedge clk);
      sclk = 1'b1;
      repeat (4) @(negedge clk);
      rep[i] = misoOeB_ff ? 1'bx : miso_ff;
      sclk = 1'b0;
    end
    repeat (4) @(negedge clk);
    csB  = 1'b1;
    mosi = ~mosi;
    repeat (6) @(negedge clk);
  endtask : xfer
endmodule : swim_host_model

/* swim_top_tb.sv */
// Self-checking bench for the switch interrupt mask block.
`timescale 1ns/10ps
module swim_top_tb;
  import swim_pkg::*;
  localparam int TL = 10;  // Shortened tick so sleep intervals stay brief.
  logic        clk, rst_b, faultIn, sleep_mode, wakeEnableAny;
  logic [7:0]  programmable_input;
  logic [13:0] ground_sense_input;
  logic        sclk, csB, mosi, miso_ff, misoOeB_ff, irqB_ff;
  logic        wakeUp_ff, gndPollOn_ff, batPollOn_ff;
  int          error_cnt = 0, n_checks = 0, n, m;
  logic [31:0] r;
  swim_top #(.TICK_LEN(TL)) DUT (.clk, .rst_b, .sclk, .csB, .mosi, .miso_ff, .misoOeB_ff,
    .programmable_input, .ground_sense_input, .faultIn, .sleep_mode, .wakeEnableAny,
    .irqB_ff, .wakeUp_ff, .gndPollOn_ff, .batPollOn_ff);
  swim_host_model host (.clk, .miso_ff, .misoOeB_ff, .sclk, .csB, .mosi);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [6:0] a, input logic [23:0] d);
    host.xfer({a, 1'b1, d}, 32, r);
  endtask : wr
  // The reply carries the previous frame's register, so a read takes two frames.
  task automatic rd(input logic [6:0] a);
    host.xfer({a, 1'b0, 24'h000000}, 32, r);
    host.xfer(32'h00000000, 32, r);
  endtask : rd
  // Counts cycles until the wake pulse (0), poll window high (1) or low (2).
  task automatic wt(input int s);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (!(s == 0 ? wakeUp_ff : s == 1 ? gndPollOn_ff : !gndPollOn_ff) && n < 9000);
  endtask : wt
  task automatic t_regs;
    logic [6:0]  a[4] = '{ADDR_PROG_MASK, ADDR_GND_MASK, ADDR_SLEEP_CFG, 7'h10};
    logic [23:0] v[4] = '{PROG_MASK_RST, GND_MASK_RST, SLEEP_CFG_RST, 24'h000000};
    logic [23:0] b[4] = '{PROG_MASK_BITS, GND_MASK_BITS, SLEEP_CFG_BITS, 24'h000000};
    for (int i = 0; i < 4; i++) begin
      rd(a[i]);
      chk(r, {10'h000, v[i][21:0]});
      wr(a[i], 24'ha5a5a5);
      rd(a[i]);
      chk(r, {10'h000, b[i][21:0] & 22'h25a5a5});
      wr(a[i], v[i]);
    end
    host.xfer({ADDR_PROG_MASK, 1'b1, 24'h000000}, 16, r);
    rd(ADDR_PROG_MASK);
    chk(r, {10'h000, PROG_MASK_RST[21:0]});
  endtask : t_regs
  task automatic t_irq;
    wr(ADDR_PROG_MASK, 24'h000001);
    wr(ADDR_GND_MASK, 24'h000000);
    programmable_input[1] = 1'b1;
    ground_sense_input[3] = 1'b1;
    repeat (20) @(negedge clk);
    chk(irqB_ff, 1'b1);
    programmable_input[0] = 1'b1;
    faultIn = 1'b1;
    repeat (20) @(negedge clk);
    chk(irqB_ff, 1'b0);
    host.xfer(32'h00000000, 32, r);
    chk(r, 32'h00c00000);
    faultIn = 1'b0;
    wr(ADDR_PROG_MASK, PROG_MASK_RST);
    wr(ADDR_GND_MASK, GND_MASK_RST);
  endtask : t_irq
  task automatic t_sleep;
    wr(ADDR_SLEEP_CFG, 24'h00008f);
    sleep_mode = 1'b1;
    wt(0);
    wt(0);
    chk(n >= 40 * TL && n <= 40 * TL + 2, 1'b1);
    wt(2);
    wt(1);
    chk(batPollOn_ff, 1'b1);
    wt(2);
    m = n;
    chk(m, GND_POLL_CYCLES);
    wt(1);
    chk(m + n, 640 * TL);
    wakeEnableAny = 1'b0;
    sleep_mode = 1'b0;
    wr(ADDR_SLEEP_CFG, 24'h00000f);
    sleep_mode = 1'b1;
    m = 0;
    repeat (7000) begin
      @(negedge clk);
      m += (wakeUp_ff !== 1'b0) + (gndPollOn_ff !== 1'b0);
    end
    chk(m, 0);
  endtask : t_sleep
  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done
  initial begin
    {rst_b, faultIn, sleep_mode, programmable_input, ground_sense_input} = '0;
    wakeEnableAny = 1'b1;
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    t_regs();
    t_irq();
    t_sleep();
    test_done();
  end
  // Watchdog sized well above the expected run of about 29000 cycles.
  initial begin
    repeat (100000) @(posedge clk);
    error_cnt++;
    test_done();
  end
endmodule : swim_top_tb
